// ===== shared/tester_ext_io_regs.vh
// Constants for the external control port of an insulation tester.
// Assumes a 100 MHz REF_CLK and a plain strobe register port.
//
// What this block does
// - A start edge begins a test and switches the test voltage on.
// - A stop edge ends the running test and shuts the voltage off.
// - With interlock enabled, open input means on, shorted means off.
// - While interlock is on, every start request is ignored.
// - Interlock turning on during a test stops that test at once.
// - The four preset_select levels choose a saved condition panel.
// - Any preset_select line high holds key lock, rejecting panel keys other than stop.
// - judge_ok follows a pass judgment of the measured value.
// - over_limit follows a value above the upper limit.
// - under_limit follows a value below the lower limit that is not also above the upper limit.
// - measuring_active during tests; during discharge per off-timing setting.
// - fault_flag on contact, short or output voltage error.
// - fault_flag driven only when contact or short check is enabled.
// - radix_position shows the decimal point while decimal output is used.
// - Extended variant outputs four BCD digits on a 16-bit bus.
// - While conditions change, start requests, the stop pin and panel keys other than stop are ignored; outputs other than radix_position held invalid.
// - After a test voltage change, start detection may take 500 ms more.
`ifndef TESTER_EXT_IO_REGS_VH
`define TESTER_EXT_IO_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LIMITS 8'h08
`define REG_VALUE 8'h0C
`define REG_CMD 8'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_ILK_EN 0
`define CTRL_CONTACT_EN 1
`define CTRL_SHORT_EN 2
`define CTRL_TEST_HOLD 3
`define CTRL_BCD_EN 4
`define CTRL_W 5
`define CTRL_RESET 5'h00
`define LIMITS_RESET 32'h9999_0000
`define CMD_START 0
`define CMD_STOP 1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 100000000
`define TICK_US 1000
`define DETECT_MS 5
`define HOLDOFF_MS 500
`define DISCH_MS 20

`endif

// ===== design/tester_ext_io_control.v
// External control port logic of an insulation tester.
// Assumes pins are synchronous to REF_CLK and the measurement core
// reports values, errors and test completion as one-cycle pulses.
`timescale 1ns/1ps
`include "tester_ext_io_regs.vh"

module tester_ext_io_control #(
    parameter EXTENDED = 1,
    parameter TICK_CYC = (`CLK_HZ / 1000000) * `TICK_US,
    parameter HOLDOFF_TICKS = `HOLDOFF_MS,
    parameter DISCH_TICKS = `DISCH_MS
) (
    // Clock and reset
    input wire REF_CLK,
    input wire RST_N,
    // Register port
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WE,
    input wire REG_RE,
    output reg [31:0] REG_RDATA,
    // Controller inputs
    input wire START_IN,
    input wire STOP_IN,
    input wire INTERLOCK_SHORTED,
    input wire [3:0] PRESET_SELECT,
    // Front panel
    input wire KEY_START,
    input wire KEY_STOP,
    input wire KEY_REQ,
    output wire KEY_ACCEPT,
    output wire KEY_LOCK,
    // Measurement core
    input wire COND_CHANGING,
    input wire VOLTAGE_CHANGED,
    input wire TEST_DONE,
    input wire MEAS_VALID,
    input wire [15:0] MEAS_VALUE,
    input wire [2:0] MEAS_RADIX,
    input wire CONTACT_ERR,
    input wire SHORT_ERR,
    input wire VOLT_ERR,
    output reg HV_ON,
    output reg [3:0] PANEL_NUM,
    output reg PANEL_LOAD,
    // Controller outputs
    output reg MEASURING_ACTIVE,
    output reg JUDGE_OK,
    output reg OVER_LIMIT,
    output reg UNDER_LIMIT,
    output reg FAULT_FLAG,
    output reg [2:0] RADIX_POSITION,
    output reg [15:0] DECIMAL_VALUE_BUS
);

// ----------------------------------------
// Constants
// ----------------------------------------
localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_WAIT = 2'd1;
localparam [1:0] ST_TEST = 2'd2;
localparam [1:0] ST_DISCH = 2'd3;
// Two stable ticks confirm a level, so detection stays under 5 ms
localparam [2:0] DETECT_TICKS = 3'd2;

// ----------------------------------------
// Reset release
// ----------------------------------------
reg [1:0] rst_sync_q;
wire rst_n;

always @(posedge REF_CLK or negedge RST_N)
begin
    if (!RST_N)
        rst_sync_q <= 2'b00;
    else
        rst_sync_q <= {rst_sync_q[0], 1'b1};
end
assign rst_n = rst_sync_q[1];

// ----------------------------------------
// Millisecond tick
// ----------------------------------------
reg [31:0] tick_cnt_q;
wire tick;

assign tick = (tick_cnt_q == TICK_CYC - 1);

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
        tick_cnt_q <= 32'h0000_0000;
    else if (tick)
        tick_cnt_q <= 32'h0000_0000;
    else
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
end

// ----------------------------------------
// Registers
// ----------------------------------------
reg [`CTRL_W-1:0] ctrl_q;
reg [31:0] limits_q;
reg [15:0] value_q;
reg sw_start_q;
reg sw_stop_q;
reg [1:0] state_q;
reg fault_q;
wire ilk_on;
wire busy;

assign busy = COND_CHANGING;
// Open input means interlock on, only when the feature is enabled
assign ilk_on = ctrl_q[`CTRL_ILK_EN] & ~INTERLOCK_SHORTED;

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        ctrl_q <= `CTRL_RESET;
        limits_q <= `LIMITS_RESET;
        sw_start_q <= 1'b0;
        sw_stop_q <= 1'b0;
    end
    else
    begin
        sw_start_q <= REG_WE && (REG_ADDR == `REG_CMD) && REG_WDATA[`CMD_START];
        sw_stop_q <= REG_WE && (REG_ADDR == `REG_CMD) && REG_WDATA[`CMD_STOP];
        if (REG_WE && REG_ADDR == `REG_CTRL)
            ctrl_q <= REG_WDATA[`CTRL_W-1:0];
        if (REG_WE && REG_ADDR == `REG_LIMITS)
            limits_q <= REG_WDATA;
    end
end

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
        REG_RDATA <= 32'h0000_0000;
    else if (REG_RE)
    begin
        case (REG_ADDR)
            `REG_CTRL: REG_RDATA <= {{(32-`CTRL_W){1'b0}}, ctrl_q};
            `REG_STATUS: REG_RDATA <= {20'h0_0000, PANEL_NUM, KEY_LOCK, ilk_on, fault_q,
                                       UNDER_LIMIT, OVER_LIMIT, JUDGE_OK, state_q};
            `REG_LIMITS: REG_RDATA <= limits_q;
            `REG_VALUE: REG_RDATA <= {16'h0000, value_q};
            default: REG_RDATA <= 32'h0000_0000;
        endcase
    end
end

// ----------------------------------------
// Start and stop edge detection
// ----------------------------------------
// Sampling on the tick filters contact bounce; a 5 ms pulse spans
// at least four ticks so it is never missed.
reg [2:0] start_run_q;
reg [2:0] stop_run_q;
reg start_lvl_q;
reg stop_lvl_q;
reg start_edge_q;
reg stop_edge_q;

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        start_run_q <= 3'd0;
        stop_run_q <= 3'd0;
        start_lvl_q <= 1'b0;
        stop_lvl_q <= 1'b0;
        start_edge_q <= 1'b0;
        stop_edge_q <= 1'b0;
    end
    else
    begin
        start_edge_q <= 1'b0;
        stop_edge_q <= 1'b0;
        if (tick)
        begin
            start_run_q <= (START_IN != start_lvl_q) ? start_run_q + 3'd1 : 3'd0;
            stop_run_q <= (STOP_IN != stop_lvl_q) ? stop_run_q + 3'd1 : 3'd0;
            if (START_IN != start_lvl_q && start_run_q + 3'd1 == DETECT_TICKS)
            begin
                start_lvl_q <= START_IN;
                start_edge_q <= START_IN;
                start_run_q <= 3'd0;
            end
            if (STOP_IN != stop_lvl_q && stop_run_q + 3'd1 == DETECT_TICKS)
            begin
                stop_lvl_q <= STOP_IN;
                stop_edge_q <= STOP_IN;
                stop_run_q <= 3'd0;
            end
        end
    end
end

// ----------------------------------------
// Panel selection and key lock
// ----------------------------------------
assign KEY_LOCK = |PRESET_SELECT;
assign KEY_ACCEPT = KEY_REQ & ~KEY_LOCK & ~busy;

// Conditions are only reloaded between tests
always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        PANEL_NUM <= 4'h0;
        PANEL_LOAD <= 1'b0;
    end
    else
    begin
        PANEL_LOAD <= 1'b0;
        if (KEY_LOCK && !busy && state_q == ST_IDLE && PRESET_SELECT != PANEL_NUM)
        begin
            PANEL_NUM <= PRESET_SELECT;
            PANEL_LOAD <= 1'b1;
        end
    end
end

// ----------------------------------------
// Test sequencer
// ----------------------------------------
reg [31:0] hold_cnt_q;
reg [31:0] disch_cnt_q;
wire start_req;
wire stop_req;

// Front-panel start is a key too, so key lock gates it
assign start_req = !busy && (start_edge_q || sw_start_q || (KEY_START && !KEY_LOCK));
assign stop_req = (!busy && stop_edge_q) || sw_stop_q || KEY_STOP;

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
        hold_cnt_q <= 32'h0000_0000;
    else if (VOLTAGE_CHANGED)
        hold_cnt_q <= HOLDOFF_TICKS;
    else if (tick && hold_cnt_q != 32'h0000_0000)
        hold_cnt_q <= hold_cnt_q - 32'h0000_0001;
end

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        state_q <= ST_IDLE;
        HV_ON <= 1'b0;
        disch_cnt_q <= 32'h0000_0000;
    end
    else
    begin
        case (state_q)
            ST_IDLE:
                if (start_req && !ilk_on)
                    state_q <= ST_WAIT;
            ST_WAIT:
                if (ilk_on || stop_req)
                    state_q <= ST_IDLE;
                else if (hold_cnt_q == 32'h0000_0000)
                begin
                    state_q <= ST_TEST;
                    HV_ON <= 1'b1;
                end
            ST_TEST:
                if (ilk_on || stop_req || TEST_DONE)
                begin
                    state_q <= ST_DISCH;
                    HV_ON <= 1'b0;
                    disch_cnt_q <= DISCH_TICKS;
                end
            ST_DISCH:
                if (disch_cnt_q == 32'h0000_0000)
                    state_q <= ST_IDLE;
                else if (tick)
                    disch_cnt_q <= disch_cnt_q - 32'h0000_0001;
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------
// Judgment and outputs
// ----------------------------------------
// Valid BCD orders like binary, so limits compare directly
wire above;
wire below;
wire testing;
wire new_test;

assign above = MEAS_VALUE > limits_q[31:16];
assign below = MEAS_VALUE < limits_q[15:0];
assign testing = (state_q == ST_TEST);
assign new_test = (state_q == ST_WAIT) && (hold_cnt_q == 32'h0000_0000) && !ilk_on && !stop_req;

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        JUDGE_OK <= 1'b0;
        OVER_LIMIT <= 1'b0;
        UNDER_LIMIT <= 1'b0;
        fault_q <= 1'b0;
        value_q <= 16'h0000;
        RADIX_POSITION <= 3'b000;
    end
    // Judgments made under old conditions mean nothing once they change
    else if (new_test || busy)
    begin
        JUDGE_OK <= 1'b0;
        OVER_LIMIT <= 1'b0;
        UNDER_LIMIT <= 1'b0;
        fault_q <= 1'b0;
    end
    else if (testing)
    begin
        if (MEAS_VALID)
        begin
            JUDGE_OK <= !above && !below;
            OVER_LIMIT <= above;
            UNDER_LIMIT <= below && !above;
            value_q <= MEAS_VALUE;
            RADIX_POSITION <= ctrl_q[`CTRL_BCD_EN] ? MEAS_RADIX : 3'b000;
        end
        if (CONTACT_ERR || SHORT_ERR || VOLT_ERR)
            fault_q <= 1'b1;
    end
end

// Outputs read as inactive while conditions are being changed
always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        MEASURING_ACTIVE <= 1'b0;
        FAULT_FLAG <= 1'b0;
        DECIMAL_VALUE_BUS <= 16'h0000;
    end
    else
    begin
        MEASURING_ACTIVE <= !busy && (testing ||
            (state_q == ST_DISCH && ctrl_q[`CTRL_TEST_HOLD]));
        FAULT_FLAG <= !busy && fault_q &&
            (ctrl_q[`CTRL_CONTACT_EN] || ctrl_q[`CTRL_SHORT_EN]);
        if (EXTENDED != 0 && ctrl_q[`CTRL_BCD_EN] && !busy)
            DECIMAL_VALUE_BUS <= value_q;
        else
            DECIMAL_VALUE_BUS <= 16'h0000;
    end
end

endmodule // tester_ext_io_control

// ===== tb/ctrl_model.sv
// Controller model driving start, stop, interlock and preset lines.
// Assumes the bench calls its tasks from the REF_CLK domain.
`timescale 1ns/1ps
module ctrl_model #(
    parameter TICK_CYC = 4
) (
    input wire clk,
    output logic start_q,
    output logic stop_q,
    output logic ilk_shorted_q,
    output logic [3:0] preset_q
);
    initial
    begin
        start_q = 1'b0;
        stop_q = 1'b0;
        ilk_shorted_q = 1'b1;
        preset_q = 4'h0;
    end
    // One tick past the minimum width, so detection never rides the limit
    task automatic pulse(input bit is_stop);
        @(posedge clk);
        start_q <= !is_stop;
        stop_q <= is_stop;
        repeat (6 * TICK_CYC) @(posedge clk);
        start_q <= 1'b0;
        stop_q <= 1'b0;
    endtask
    task automatic set_lines(input bit shorted, input logic [3:0] panel);
        @(posedge clk);
        ilk_shorted_q <= shorted;
        preset_q <= panel;
    endtask
endmodule // ctrl_model

// ===== tb/tester_ext_io_checker.sv
// Assertions on the external control port, from top-level ports only.
// Assumes control and limits change only through register writes.
`timescale 1ns/1ps
`include "tester_ext_io_regs.vh"
module tester_ext_io_checker (
    input wire REF_CLK,
    input wire RST_N,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WE,
    input wire INTERLOCK_SHORTED,
    input wire [3:0] PRESET_SELECT,
    input wire KEY_ACCEPT,
    input wire KEY_LOCK,
    input wire COND_CHANGING,
    input wire MEAS_VALID,
    input wire [15:0] MEAS_VALUE,
    input wire [2:0] MEAS_RADIX,
    input wire HV_ON,
    input wire MEASURING_ACTIVE,
    input wire JUDGE_OK,
    input wire OVER_LIMIT,
    input wire UNDER_LIMIT,
    input wire FAULT_FLAG,
    input wire [2:0] RADIX_POSITION,
    input wire [15:0] DECIMAL_VALUE_BUS
);
    logic [4:0] ctrl_q;
    logic [31:0] lim_q;
    logic [2:0] jexp;
    logic ilk_on;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    // Shadow of writable fields, so rules can be judged from the pins
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_q <= 5'h00;
            lim_q <= 32'h9999_0000;
        end
        else if (REG_WE && REG_ADDR == `REG_CTRL)
            ctrl_q <= REG_WDATA[4:0];
        else if (REG_WE && REG_ADDR == `REG_LIMITS)
            lim_q <= REG_WDATA;
    end
    assign ilk_on = ctrl_q[0] && !INTERLOCK_SHORTED;
    assign jexp = (MEAS_VALUE > lim_q[31:16]) ? 3'b010 : (MEAS_VALUE < lim_q[15:0]) ? 3'b001 : 3'b100;
    sequence s_meas;
        MEAS_VALID && HV_ON && !COND_CHANGING ##1 !COND_CHANGING;
    endsequence
    property p_key;
        KEY_LOCK == (|PRESET_SELECT) && !(KEY_ACCEPT && KEY_LOCK);
    endproperty
    a_key: assert property (p_key) else $error("key lock wrong");
    property p_one;
        $onehot0({JUDGE_OK, OVER_LIMIT, UNDER_LIMIT});
    endproperty
    a_one: assert property (p_one) else $error("two judgments");
    property p_clear;
        $rose(HV_ON) |=> !(JUDGE_OK || OVER_LIMIT || UNDER_LIMIT);
    endproperty
    a_clear: assert property (p_clear) else $error("judgment kept");
    property p_judge;
        s_meas |-> {JUDGE_OK, OVER_LIMIT, UNDER_LIMIT} == $past(jexp);
    endproperty
    a_judge: assert property (p_judge) else $error("judgment wrong");
    property p_value;
        s_meas ##0 ($past(ctrl_q[4]) && ctrl_q[4]) |-> (RADIX_POSITION == $past(MEAS_RADIX))
            ##1 (DECIMAL_VALUE_BUS == $past(MEAS_VALUE, 2));
    endproperty
    a_value: assert property (p_value) else $error("value bus wrong");
    property p_active;
        HV_ON && $past(HV_ON) && !COND_CHANGING && !$past(COND_CHANGING) |-> MEASURING_ACTIVE;
    endproperty
    a_active: assert property (p_active) else $error("active low in test");
    property p_ilk_block;
        ilk_on && $past(ilk_on) |-> !$rose(HV_ON);
    endproperty
    a_ilk_block: assert property (p_ilk_block) else $error("start under lock");
    property p_ilk_stop;
        ilk_on && HV_ON |-> ##[1:4] !HV_ON;
    endproperty
    a_ilk_stop: assert property (p_ilk_stop) else $error("lock not stopping");
    property p_fault;
        FAULT_FLAG |-> ctrl_q[2:1] != 2'b00 || $past(ctrl_q[2:1]) != 2'b00;
    endproperty
    a_fault: assert property (p_fault) else $error("fault while checks off");
    property p_cond;
        COND_CHANGING && $past(COND_CHANGING) |-> !(MEASURING_ACTIVE || JUDGE_OK || OVER_LIMIT || UNDER_LIMIT || FAULT_FLAG);
    endproperty
    a_cond: assert property (p_cond) else $error("output while changing");
endmodule // tester_ext_io_checker
bind tester_ext_io_control tester_ext_io_checker tester_ext_io_checker_inst (.*);

// ===== tb/tester_ext_io_control_tb.sv
// Testbench for the external control port: registers, pins, core pulses.
// Assumes the checker bind and the controller model are compiled first.
`timescale 1ns/1ps
`include "tester_ext_io_regs.vh"
module tester_ext_io_control_tb;
    localparam int TICK = 4;
    logic REF_CLK = 1'b0, RST_N = 1'b0, REG_WE = 1'b0, REG_RE = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0000_0000;
    logic COND_CHANGING = 1'b0, MEAS_VALID = 1'b0, VOLTAGE_CHANGED = 1'b0, TEST_DONE = 1'b0;
    logic CONTACT_ERR = 1'b0, KEY_REQ = 1'b0, KEY_START = 1'b0, KEY_STOP = 1'b0, SHORT_ERR = 1'b0, VOLT_ERR = 1'b0;
    logic [15:0] MEAS_VALUE = 16'h0000;
    logic [2:0] MEAS_RADIX = 3'h0;
    wire START_IN, STOP_IN, INTERLOCK_SHORTED, KEY_ACCEPT, KEY_LOCK, HV_ON, PANEL_LOAD, MEASURING_ACTIVE;
    wire JUDGE_OK, OVER_LIMIT, UNDER_LIMIT, FAULT_FLAG;
    wire [3:0] PRESET_SELECT, PANEL_NUM;
    wire [2:0] RADIX_POSITION;
    wire [15:0] DECIMAL_VALUE_BUS;
    wire [31:0] REG_RDATA;
    int miscompares = 0, num_checks = 0, cycles = 0;
    always #5 REF_CLK = ~REF_CLK;
    tester_ext_io_control #(.EXTENDED(1), .TICK_CYC(TICK), .HOLDOFF_TICKS(3), .DISCH_TICKS(2))
        tester_ext_io_control_inst (.*);
    ctrl_model #(.TICK_CYC(TICK)) ctrl_model_inst (.clk(REF_CLK), .start_q(START_IN), .stop_q(STOP_IN),
        .ilk_shorted_q(INTERLOCK_SHORTED), .preset_q(PRESET_SELECT));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WE <= 1'b1;
        @(posedge REF_CLK);
        REG_WE <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_RE <= 1'b1;
        @(posedge REF_CLK);
        REG_RE <= 1'b0;
        #1 chk(REG_RDATA, exp);
    endtask
    // Bit 7-k of the core strobes, high for one cycle
    task automatic strobe(input int k, input logic acc);
        @(posedge REF_CLK);
        {VOLTAGE_CHANGED, TEST_DONE, CONTACT_ERR, KEY_REQ, SHORT_ERR, VOLT_ERR, KEY_START, KEY_STOP} <= 8'h80 >> k;
        #1 chk(KEY_ACCEPT, acc);
        @(posedge REF_CLK);
        {VOLTAGE_CHANGED, TEST_DONE, CONTACT_ERR, KEY_REQ, SHORT_ERR, VOLT_ERR, KEY_START, KEY_STOP} <= 8'h00;
    endtask
    task automatic wait_hv(input logic v);
        int n = 0;
        while (HV_ON !== v && n < 300)
        begin
            @(posedge REF_CLK);
            n++;
        end
        #1 chk(HV_ON, v);
    endtask
    task automatic meas(input logic [15:0] v, input logic [2:0] r, input logic [2:0] exp);
        @(posedge REF_CLK);
        MEAS_VALID <= 1'b1;
        MEAS_VALUE <= v;
        MEAS_RADIX <= r;
        @(posedge REF_CLK);
        MEAS_VALID <= 1'b0;
        @(posedge REF_CLK);
        #1 chk({JUDGE_OK, OVER_LIMIT, UNDER_LIMIT}, exp);
        chk(DECIMAL_VALUE_BUS, v);
        chk(RADIX_POSITION, r);
    endtask
    always @(posedge REF_CLK)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        rd(`REG_CTRL, 32'h0000_0000);
        rd(`REG_LIMITS, 32'h9999_0000);
        wr(`REG_CTRL, 32'hFFFF_FFFF);
        rd(`REG_CTRL, 32'h0000_001F);
        rd(8'h3C, 32'h0000_0000);
        $display("registers done");
        wr(`REG_CTRL, 32'h0000_0016);
        wr(`REG_LIMITS, 32'h5000_1000);
        strobe(0, 1'b0);
        ctrl_model_inst.pulse(1'b0);
        wait_hv(1'b1);
        repeat (2) @(posedge REF_CLK);
        #1 chk(MEASURING_ACTIVE, 1'b1);
        meas(16'h6000, 3'b111, 3'b010);
        meas(16'h0500, 3'b011, 3'b001);
        meas(16'h2345, 3'b110, 3'b100);
        rd(`REG_VALUE, 32'h0000_2345);
        strobe(2, 1'b0);
        @(posedge REF_CLK);
        #1 chk(FAULT_FLAG, 1'b1);
        wr(`REG_CTRL, 32'h0000_0010);
        @(posedge REF_CLK);
        #1 chk(FAULT_FLAG, 1'b0);
        strobe(1, 1'b0);
        wait_hv(1'b0);
        // A start that lands during discharge is dropped, so let it finish
        repeat (4 * TICK) @(posedge REF_CLK);
        ctrl_model_inst.pulse(1'b0);
        wait_hv(1'b1);
        @(posedge REF_CLK);
        #1 chk({JUDGE_OK, OVER_LIMIT, UNDER_LIMIT}, 3'b000);
        strobe(5, 1'b0);
        wr(`REG_CTRL, 32'h0000_0014);
        @(posedge REF_CLK);
        #1 chk(FAULT_FLAG, 1'b1);
        ctrl_model_inst.pulse(1'b1);
        wait_hv(1'b0);
        $display("test cycle done");
        wr(`REG_CTRL, 32'h0000_0001);
        ctrl_model_inst.set_lines(1'b0, 4'h0);
        ctrl_model_inst.pulse(1'b0);
        repeat (8) @(posedge REF_CLK);
        #1 chk(HV_ON, 1'b0);
        ctrl_model_inst.set_lines(1'b1, 4'h0);
        ctrl_model_inst.pulse(1'b0);
        wait_hv(1'b1);
        ctrl_model_inst.set_lines(1'b0, 4'h0);
        wait_hv(1'b0);
        ctrl_model_inst.set_lines(1'b1, 4'h0);
        $display("interlock done");
        repeat (4 * TICK) @(posedge REF_CLK);
        ctrl_model_inst.set_lines(1'b1, 4'h5);
        @(posedge REF_CLK);
        #1 chk(PANEL_LOAD, 1'b1);
        repeat (4 * TICK) @(posedge REF_CLK);
        #1 chk(PANEL_NUM, 4'h5);
        chk(KEY_LOCK, 1'b1);
        chk(PANEL_LOAD, 1'b0);
        strobe(3, 1'b0);
        strobe(6, 1'b0);
        ctrl_model_inst.set_lines(1'b1, 4'h0);
        repeat (4 * TICK) @(posedge REF_CLK);
        #1 chk(PANEL_NUM, 4'h5);
        chk(HV_ON, 1'b0);
        strobe(3, 1'b1);
        strobe(6, 1'b0);
        wait_hv(1'b1);
        strobe(4, 1'b0);
        rd(`REG_STATUS, 32'h0000_0522);
        chk(FAULT_FLAG, 1'b0);
        strobe(7, 1'b0);
        wait_hv(1'b0);
        $display("preset done");
        repeat (4 * TICK) @(posedge REF_CLK);
        wr(`REG_CTRL, 32'h0000_0010);
        wr(`REG_CMD, 32'h0000_0001);
        wait_hv(1'b1);
        meas(16'h0700, 3'b101, 3'b001);
        wr(`REG_CMD, 32'h0000_0002);
        wait_hv(1'b0);
        $display("command done");
        @(posedge REF_CLK);
        COND_CHANGING <= 1'b1;
        ctrl_model_inst.pulse(1'b0);
        repeat (4) @(posedge REF_CLK);
        #1 chk(HV_ON, 1'b0);
        chk(MEASURING_ACTIVE, 1'b0);
        chk({JUDGE_OK, OVER_LIMIT, UNDER_LIMIT}, 3'b000);
        @(posedge REF_CLK);
        COND_CHANGING <= 1'b0;
        $display("condition change done");
        tally_and_finish();
    end
endmodule // tester_ext_io_control_tb
